/* sfr_bank0_defines.svh */
// address map, field positions and reset attributes of the bank-zero register map
`ifndef SFR_BANK0_DEFINES_SVH
`define SFR_BANK0_DEFINES_SVH

// --------------------------------------------------------------------------
// addresses inside a bank
// --------------------------------------------------------------------------
`define ADR_INDIRECT_ACCESS    5'h00
`define ADR_TIMER0_COUNT       5'h01
`define ADR_PC_LOW             5'h02
`define ADR_CORE_STATUS        5'h03
`define ADR_INDIRECT_POINTER   5'h04
`define ADR_PORT_A             5'h05
`define ADR_PORT_B             5'h06
`define ADR_PORT_C             5'h07
`define ADR_GAP_0              5'h08
`define ADR_GAP_1              5'h09
`define ADR_PC_HIGH_LATCH      5'h0A
`define ADR_INTERRUPT_CONTROL  5'h0B
`define ADR_PERIPH_FLAGS_ONE   5'h0C
`define ADR_PERIPH_FLAGS_TWO   5'h0D
`define ADR_TIMER1_LOW         5'h0E
`define ADR_TIMER1_HIGH        5'h0F
`define ADR_TIMER1_CONTROL     5'h10
`define ADR_TIMER2_COUNT       5'h11
`define ADR_TIMER2_CONTROL     5'h12
`define ADR_SERIAL_BUFFER      5'h13
`define ADR_SERIAL_CONTROL     5'h14
`define ADR_COMPARE1_LOW       5'h15
`define ADR_COMPARE1_HIGH      5'h16
`define ADR_COMPARE1_CONTROL   5'h17
`define ADR_RECEIVE_STATUS     5'h18
`define ADR_COMPARE2_LOW       5'h1B
`define ADR_COMPARE2_HIGH      5'h1C
`define ADR_COMPARE2_CONTROL   5'h1D
`define ADR_GAP_2              5'h1E
`define ADR_GAP_3              5'h1F

// --------------------------------------------------------------------------
// implemented-bit masks, reset values, bits kept on other resets
// --------------------------------------------------------------------------
`define MASK_FULL              8'hFF
`define MASK_NONE              8'h00
`define MASK_SIX               8'h3F
`define MASK_FIVE              8'h1F
`define MASK_ONE               8'h01
`define MASK_SEVEN             8'h7F
`define MASK_RECEIVE_STATUS    8'hF7
`define MASK_STATUS_FLAGS      8'h18
`define KEEP_STATUS_ARITH      8'h07
`define POR_STATUS             8'h18
`define ZERO_BYTE              8'h00

// --------------------------------------------------------------------------
// status fields, pc high-bit positions and register count
// --------------------------------------------------------------------------
`define ST_IRP                 7
`define ST_RP1                 6
`define ST_RP0                 5
`define ST_TIMEOUT             4
`define ST_POWER_DOWN          3
`define PC_HIGH_LSB            8
`define PC_HIGH_MSB            12
`define REG_COUNT              32

`endif

/* sfr_bank0_pkg.sv */
// types shared by the bank-zero register map
package sfr_bank0_pkg;

	// one core data-memory access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// reset attributes of one location
	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] por;
		logic [7:0] keep;
	} reg_attr_t;

	typedef enum logic [1:0] {
		cause_none,
		cause_master_clear,
		cause_watchdog
	} reset_cause_t;

endpackage : sfr_bank0_pkg

/* sfr_bank0.sv */
// bank-zero special function register map of the core
// Notes on behaviour
// - unimplemented bits inside an implemented register always read as zero.
// - locations 08h, 09h, 1Eh and 1Fh read zero and ignore writes.
// - the common registers answer at the same address in every bank.
// - only the low byte of the program counter is reachable as data.
// - the five-bit high latch holds writes and fills pc bits 12..8 on every load.
// - master clear and watchdog resets load the other-reset values, not the power-on ones.
// - bits marked unchanged keep their contents over those resets; unknown bits may take any value.
// - the timeout and power-down flags follow the cause of the reset.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "sfr_bank0_defines.svh"

module sfr_bank0 import sfr_bank0_pkg::*; (
	input  wire logic     i_ref_clk,
	input  wire logic     i_resetn,
	input  wire sfr_req_t i_req,
	input  wire logic     i_master_clear_n,
	input  wire logic     i_wdt_timeout,
	input  wire logic     i_sleeping,
	input  wire logic     i_pc_advance,
	input  wire logic     i_pc_load,
	input  wire logic [7:0] i_pc_target,
	input  wire logic [5:0] i_port_a_pins,
	input  wire logic [7:0] i_port_b_pins,
	input  wire logic [7:0] i_port_c_pins,
	output logic [7:0]    o_rdata,
	output logic [12:0]   o_pc,
	output logic [5:0]    o_port_a_latch,
	output logic [7:0]    o_port_b_latch,
	output logic [7:0]    o_port_c_latch
);

	// ----------------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------------
	function automatic reg_attr_t attr_of(input logic [4:0] idx);
		reg_attr_t a;
		a.mask = `MASK_FULL;
		a.por  = `ZERO_BYTE;
		a.keep = `ZERO_BYTE;
		case (idx)
			`ADR_INDIRECT_ACCESS, `ADR_PC_LOW,
			`ADR_GAP_0, `ADR_GAP_1, `ADR_GAP_2, `ADR_GAP_3: begin
				a.mask = `MASK_NONE;
			end
			`ADR_CORE_STATUS: begin
				a.por  = `POR_STATUS;
				a.keep = `KEEP_STATUS_ARITH;
			end
			`ADR_PORT_A: begin
				a.mask = `MASK_SIX;
				a.keep = `MASK_SIX;
			end
			`ADR_PC_HIGH_LATCH:    a.mask = `MASK_FIVE;
			`ADR_INTERRUPT_CONTROL: a.keep = `MASK_ONE;
			`ADR_PERIPH_FLAGS_TWO: a.mask = `MASK_ONE;
			`ADR_TIMER1_CONTROL: begin
				a.mask = `MASK_SIX;
				a.keep = `MASK_SIX;
			end
			`ADR_TIMER2_CONTROL:   a.mask = `MASK_SEVEN;
			`ADR_COMPARE1_CONTROL, `ADR_COMPARE2_CONTROL: begin
				a.mask = `MASK_SIX;
			end
			`ADR_RECEIVE_STATUS: begin
				a.mask = `MASK_RECEIVE_STATUS;
				a.keep = `MASK_ONE;
			end
			`ADR_TIMER0_COUNT, `ADR_INDIRECT_POINTER, `ADR_PORT_B, `ADR_PORT_C,
			`ADR_TIMER1_LOW, `ADR_TIMER1_HIGH, `ADR_SERIAL_BUFFER,
			`ADR_COMPARE1_LOW, `ADR_COMPARE1_HIGH,
			`ADR_COMPARE2_LOW, `ADR_COMPARE2_HIGH: begin
				a.keep = `MASK_FULL;
			end
			default: begin
			end
		endcase
		return a;
	endfunction : attr_of

	function automatic logic [7:0] mask_of(input logic [4:0] idx);
		reg_attr_t a;
		a = attr_of(idx);
		return a.mask;
	endfunction : mask_of

	function automatic logic [7:0] por_of(input logic [4:0] idx);
		reg_attr_t a;
		a = attr_of(idx);
		return a.por;
	endfunction : por_of

	function automatic logic [7:0] keep_of(input logic [4:0] idx);
		reg_attr_t a;
		a = attr_of(idx);
		return a.keep;
	endfunction : keep_of

	function automatic logic is_common(input logic [4:0] idx);
		return (idx == `ADR_INDIRECT_ACCESS) || (idx == `ADR_PC_LOW) ||
			(idx == `ADR_CORE_STATUS) || (idx == `ADR_INDIRECT_POINTER) ||
			(idx == `ADR_PC_HIGH_LATCH) || (idx == `ADR_INTERRUPT_CONTROL);
	endfunction : is_common

	// {bank, offset} -> hit in this map; beyond 1Fh of a bank lies general memory
	function automatic logic in_map(input logic [8:0] full);
		return (full[6:5] == 2'h0) && ((full[8:7] == 2'h0) || is_common(full[4:0]));
	endfunction : in_map

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	logic [7:0]   file_reg [`REG_COUNT];
	logic [12:0]  pc_reg;
	logic [7:0]   rdata_reg;
	logic         master_clear_pin_meta_reg;
	logic         master_clear_pin_sync_reg;
	logic [5:0]   pa_meta_reg;
	logic [5:0]   pa_sync_reg;
	logic [7:0]   pb_meta_reg;
	logic [7:0]   pb_sync_reg;
	logic [7:0]   pc_meta_reg;
	logic [7:0]   pc_sync_reg;
	reset_cause_t cause;
	logic [7:0]   status;
	logic [8:0]   direct_addr;
	logic [8:0]   eff_addr;
	logic [4:0]   idx;
	logic         hit;
	logic         is_indirect;
	logic         wr_hit;
	logic         pcl_write;
	logic [7:0]   rdata_next;

	assign status = file_reg[`ADR_CORE_STATUS];

	// ----------------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		master_clear_pin_meta_reg <= i_master_clear_n;
		master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
		pa_meta_reg   <= i_port_a_pins;
		pa_sync_reg   <= pa_meta_reg;
		pb_meta_reg   <= i_port_b_pins;
		pb_sync_reg   <= pb_meta_reg;
		pc_meta_reg   <= i_port_c_pins;
		pc_sync_reg   <= pc_meta_reg;
	end

	// ----------------------------------------------------------------------
	// reset cause and address resolution
	// ----------------------------------------------------------------------
	always_comb begin
		if (!master_clear_pin_sync_reg) begin
			cause = cause_master_clear;
		end else if (i_wdt_timeout) begin
			cause = cause_watchdog;
		end else begin
			cause = cause_none;
		end
	end

	assign direct_addr = {status[`ST_RP1], status[`ST_RP0], i_req.addr};
	assign is_indirect = in_map(direct_addr) && (direct_addr[4:0] == `ADR_INDIRECT_ACCESS);
	// the pointer reaches the same map; general memory beyond it is not held here
	assign eff_addr    = is_indirect ? {status[`ST_IRP], file_reg[`ADR_INDIRECT_POINTER]} : direct_addr;
	assign idx         = eff_addr[4:0];
	assign hit         = in_map(eff_addr) && !(is_indirect && idx == `ADR_INDIRECT_ACCESS);
	assign wr_hit      = i_req.wr && hit && (cause == cause_none);
	assign pcl_write   = wr_hit && (idx == `ADR_PC_LOW);

	// ----------------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				file_reg[i] <= por_of(5'(i)) & mask_of(5'(i));
			end
		end else if (cause != cause_none) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				file_reg[i] <= file_reg[i] & keep_of(5'(i));
			end
			if (cause == cause_watchdog) begin
				file_reg[`ADR_CORE_STATUS][`ST_TIMEOUT]    <= 1'b0;
				file_reg[`ADR_CORE_STATUS][`ST_POWER_DOWN] <= !i_sleeping;
			end else if (i_sleeping) begin
				file_reg[`ADR_CORE_STATUS][`ST_TIMEOUT]    <= 1'b1;
				file_reg[`ADR_CORE_STATUS][`ST_POWER_DOWN] <= 1'b0;
			end else begin
				file_reg[`ADR_CORE_STATUS][`ST_TIMEOUT]    <= status[`ST_TIMEOUT];
				file_reg[`ADR_CORE_STATUS][`ST_POWER_DOWN] <= status[`ST_POWER_DOWN];
			end
		end else if (wr_hit) begin
			if (idx == `ADR_CORE_STATUS) begin
				// timeout and power-down are read-only to software
				file_reg[idx] <= (i_req.wdata & ~`MASK_STATUS_FLAGS) | (status & `MASK_STATUS_FLAGS);
			end else begin
				file_reg[idx] <= i_req.wdata & mask_of(idx);
			end
		end
	end

	assign o_port_a_latch = file_reg[`ADR_PORT_A][5:0];
	assign o_port_b_latch = file_reg[`ADR_PORT_B];
	assign o_port_c_latch = file_reg[`ADR_PORT_C];

	// ----------------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn || cause != cause_none) begin
			pc_reg <= 13'h0000;
		end else if (pcl_write) begin
			pc_reg <= {file_reg[`ADR_PC_HIGH_LATCH][4:0], i_req.wdata};
		end else if (i_pc_load) begin
			pc_reg <= {file_reg[`ADR_PC_HIGH_LATCH][4:0], i_pc_target};
		end else if (i_pc_advance) begin
			pc_reg <= pc_reg + 13'h0001;
		end
	end

	assign o_pc = pc_reg;

	// ----------------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------------
	always_comb begin
		rdata_next = `ZERO_BYTE;
		if (i_req.rd && hit) begin
			case (idx)
				`ADR_PC_LOW: rdata_next = pc_reg[7:0];
				`ADR_PORT_A: rdata_next = {2'h0, pa_sync_reg};
				`ADR_PORT_B: rdata_next = pb_sync_reg;
				`ADR_PORT_C: rdata_next = pc_sync_reg;
				default:     rdata_next = file_reg[idx] & mask_of(idx);
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rdata_reg <= `ZERO_BYTE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata = rdata_reg;

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_direct_read(logic [4:0] a);
		i_req.rd && !is_indirect && hit && idx == a;
	endsequence
	sequence s_other_reset;
		cause != cause_none;
	endsequence
	sequence s_quiet_run;
		cause == cause_none && !i_pc_load && !i_pc_advance;
	endsequence
	sequence s_direct_write(logic [4:0] a);
		wr_hit && !is_indirect && idx == a;
	endsequence

	property p_gap_reads_zero;
		i_req.rd && direct_addr[8:7] == 2'h0 &&
			(i_req.addr == 7'(`ADR_GAP_0) || i_req.addr == 7'(`ADR_GAP_1) ||
			i_req.addr == 7'(`ADR_GAP_2) || i_req.addr == 7'(`ADR_GAP_3)) |=> o_rdata == `ZERO_BYTE;
	endproperty
	a_gap_reads_zero: assert property (p_gap_reads_zero) else $error("gap location read nonzero");

	property p_gap_write_ignored;
		i_req.wr && i_req.addr == 7'(`ADR_GAP_2) |=> file_reg[`ADR_GAP_2] == `ZERO_BYTE;
	endproperty
	a_gap_write_ignored: assert property (p_gap_write_ignored) else $error("gap location kept a write");

	property p_latch_upper_zero;
		s_direct_read(`ADR_PC_HIGH_LATCH) |=> o_rdata[7:5] == 3'h0;
	endproperty
	a_latch_upper_zero: assert property (p_latch_upper_zero) else $error("unimplemented bits read nonzero");

	property p_port_a_upper_zero;
		s_direct_read(`ADR_PORT_A) |=> o_rdata[7:6] == 2'h0;
	endproperty
	a_port_a_upper_zero: assert property (p_port_a_upper_zero) else $error("port a upper bits read nonzero");

	property p_common_status;
		i_req.rd && !is_indirect && direct_addr[8:7] != 2'h0 && i_req.addr == 7'(`ADR_CORE_STATUS)
			|=> o_rdata == $past(status);
	endproperty
	a_common_status: assert property (p_common_status) else $error("status not common to banks");

	property p_latch_common;
		i_req.rd && i_req.addr == 7'(`ADR_PC_HIGH_LATCH) |=> o_rdata == $past(file_reg[`ADR_PC_HIGH_LATCH]);
	endproperty
	a_latch_common: assert property (p_latch_common) else $error("high latch not common to banks");

	property p_pcl_read;
		s_direct_read(`ADR_PC_LOW) |=> o_rdata == $past(pc_reg[7:0]);
	endproperty
	a_pcl_read: assert property (p_pcl_read) else $error("low pc byte read wrong");

	property p_pc_load_high;
		pcl_write ##0 s_quiet_run |=> o_pc == {$past(file_reg[`ADR_PC_HIGH_LATCH][4:0]), $past(i_req.wdata)};
	endproperty
	a_pc_load_high: assert property (p_pc_load_high) else $error("latch not copied to pc");

	property p_pc_target_load;
		i_pc_load && !pcl_write && cause == cause_none
			|=> o_pc == {$past(file_reg[`ADR_PC_HIGH_LATCH][4:0]), $past(i_pc_target)};
	endproperty
	a_pc_target_load: assert property (p_pc_target_load) else $error("latch not copied on pc load");

	property p_pc_high_hidden;
		wr_hit && idx != `ADR_PC_LOW && !i_pc_load && !i_pc_advance
			|=> o_pc == $past(o_pc);
	endproperty
	a_pc_high_hidden: assert property (p_pc_high_hidden) else $error("data write reached the pc");

	property p_other_reset_values;
		s_other_reset |=> file_reg[`ADR_PC_HIGH_LATCH] == `ZERO_BYTE && file_reg[`ADR_INTERRUPT_CONTROL][7:1] == 7'h00
			&& o_pc == 13'h0000;
	endproperty
	a_other_reset_values: assert property (p_other_reset_values) else $error("other reset values wrong");

	property p_pointer_kept;
		s_other_reset |=> file_reg[`ADR_INDIRECT_POINTER] == $past(file_reg[`ADR_INDIRECT_POINTER]);
	endproperty
	a_pointer_kept: assert property (p_pointer_kept) else $error("pointer lost over reset");

	property p_latch_kept;
		s_other_reset |=> o_port_b_latch == $past(o_port_b_latch);
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("port latch lost over reset");

	property p_watchdog_flags;
		master_clear_pin_sync_reg && i_wdt_timeout |=> !status[`ST_TIMEOUT] && status[`ST_POWER_DOWN] == !$past(i_sleeping);
	endproperty
	a_watchdog_flags: assert property (p_watchdog_flags) else $error("watchdog flags wrong");

	property p_master_clear_flags;
		cause == cause_master_clear && i_sleeping |=> status[`ST_TIMEOUT] && !status[`ST_POWER_DOWN];
	endproperty
	a_master_clear_flags: assert property (p_master_clear_flags) else $error("master clear flags wrong");

	property p_flags_kept_on_write;
		wr_hit && idx == `ADR_CORE_STATUS
			|=> status[`ST_TIMEOUT:`ST_POWER_DOWN] == $past(status[`ST_TIMEOUT:`ST_POWER_DOWN]);
	endproperty
	a_flags_kept_on_write: assert property (p_flags_kept_on_write) else $error("software moved reset flags");

	property p_indirect_write;
		wr_hit && is_indirect && idx == `ADR_PC_HIGH_LATCH
			|=> file_reg[`ADR_PC_HIGH_LATCH] == $past(i_req.wdata & `MASK_FIVE);
	endproperty
	a_indirect_write: assert property (p_indirect_write) else $error("indirect write missed target");

	property p_indirect_self;
		i_req.rd && is_indirect && file_reg[`ADR_INDIRECT_POINTER] == `ZERO_BYTE |=> o_rdata == `ZERO_BYTE;
	endproperty
	a_indirect_self: assert property (p_indirect_self) else $error("indirect location read itself");

	property p_indirect_read;
		i_req.rd && is_indirect && hit && idx == `ADR_INTERRUPT_CONTROL
			|=> o_rdata == $past(file_reg[`ADR_INTERRUPT_CONTROL]);
	endproperty
	a_indirect_read: assert property (p_indirect_read) else $error("indirect read missed target");

	property p_port_read_pins;
		s_direct_read(`ADR_PORT_B) |=> o_rdata == $past(pb_sync_reg);
	endproperty
	a_port_read_pins: assert property (p_port_read_pins) else $error("port read not pin levels");

	property p_port_latch_write;
		s_direct_write(`ADR_PORT_C) |=> o_port_c_latch == $past(i_req.wdata);
	endproperty
	a_port_latch_write: assert property (p_port_latch_write) else $error("port write missed latch");

endmodule : sfr_bank0

/* core_access_model.sv */
// core-side model of the data-memory access path into the register map
`timescale 1ns/1ps

module core_access_model import sfr_bank0_pkg::*; (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_rdata,
	output sfr_req_t        o_req
);
	initial o_req = '0;

	// --------------------
	// one access
	// --------------------
	// idle address and data are inverted, so a design that samples them outside the strobe sees garbage
	task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_ref_clk);
		o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_ref_clk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
		q = i_rdata;
	endtask : access
endmodule : core_access_model

/* bank0_special_register_map_tb.sv */
// self-checking bench of the bank-zero register map
`timescale 1ns/1ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, got, exp); end end

module bank0_special_register_map_tb;
	import sfr_bank0_pkg::*;
	logic        i_ref_clk, i_resetn, master_clear_n, wdt_timeout, sleeping, pc_advance, pc_load;
	logic [7:0]  pc_target, pins_b, pins_c, rdata, q, latch_b, latch_c;
	logic [5:0]  pins_a, latch_a;
	logic [12:0] pc, pc_m;
	sfr_req_t    req;
	logic [31:0] seed = 32'h0000_0016;
	logic [7:0]  mem [32];
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;

	sfr_bank0 sfr_bank0_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(req),
		.i_master_clear_n(master_clear_n), .i_wdt_timeout(wdt_timeout), .i_sleeping(sleeping),
		.i_pc_advance(pc_advance), .i_pc_load(pc_load), .i_pc_target(pc_target), .i_port_a_pins(pins_a),
		.i_port_b_pins(pins_b), .i_port_c_pins(pins_c), .o_rdata(rdata), .o_pc(pc),
		.o_port_a_latch(latch_a), .o_port_b_latch(latch_b), .o_port_c_latch(latch_c));
	core_access_model core_access_model_i (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_req(req));

	// --------------------
	// reference model
	// --------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	function automatic logic [7:0] msk(input logic [4:0] a);
		case (a)
			5'h05, 5'h10, 5'h17, 5'h1D: return 8'h3F;
			5'h0A: return 8'h1F;
			5'h0D: return 8'h01;
			5'h12: return 8'h7F;
			5'h18: return 8'hF7;
			5'h08, 5'h09, 5'h1E, 5'h1F: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction : msk

	function automatic logic [7:0] kp(input logic [4:0] a);
		case (a)
			5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0E, 5'h0F, 5'h10, 5'h13, 5'h15, 5'h16, 5'h1B, 5'h1C: return 8'hFF;
			5'h03: return 8'h07;
			5'h0B, 5'h18: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction : kp

	function automatic logic common(input logic [4:0] a);
		return a == 5'h00 || a == 5'h02 || a == 5'h03 || a == 5'h04 || a == 5'h0A || a == 5'h0B;
	endfunction : common

	// pointer target of the indirect location, zero when it leaves this bank-zero map
	function automatic logic [4:0] ind();
		return (mem[4][7:5] != 3'h0 || mem[3][7]) ? 5'h00 : mem[4][4:0];
	endfunction : ind

	function automatic logic [7:0] ev(input logic [6:0] a);
		logic [4:0] t;
		t = (a == 7'h00) ? ind() : a[4:0];
		if (a[6:5] != 2'h0 || (mem[3][6:5] != 2'h0 && !common(a[4:0])))
			return 8'h00;
		case (t)
			5'h00: return 8'h00;
			5'h02: return pc_m[7:0];
			5'h05: return {2'h0, pins_a};
			5'h06: return pins_b;
			5'h07: return pins_c;
			default: return mem[t];
		endcase
	endfunction : ev

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [4:0] t;
		core_access_model_i.access(1'b1, a, d, q);
		t = (a == 7'h00) ? ind() : a[4:0];
		if (a[6:5] != 2'h0 || t == 5'h00 || (mem[3][6:5] != 2'h0 && !common(a[4:0])))
			return;
		if (t == 5'h02)
			pc_m = {mem[10][4:0], d};
		else if (t == 5'h03)
			mem[3] = {d[7:5], mem[3][4:3], d[2:0]};
		else
			mem[t] = d & msk(t);
	endtask : wr

	task automatic rd(input logic [6:0] a);
		core_access_model_i.access(1'b0, a, 8'h00, q);
		`CHK(q, ev(a))
	endtask : rd

	task automatic rd_all();
		for (int a = 0; a < 32; a++)
			rd(7'(a));
	endtask : rd_all

	task automatic other_reset(input logic wdt);
		logic [1:0] f;
		f = mem[3][4:3];
		for (int i = 0; i < 32; i++)
			mem[i] = mem[i] & kp(5'(i));
		pc_m = 13'h0000;
		mem[3][4:3] = wdt ? {1'b0, !sleeping} : (sleeping ? 2'h2 : f);
	endtask : other_reset

	task automatic results();
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// --------------------
	// clock and watchdog on the run
	// --------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			results();
		end
	end

	// --------------------
	// scenarios
	// --------------------
	initial begin
		i_resetn = 1'b0;
		master_clear_n = 1'b1;
		wdt_timeout = 1'b0;
		sleeping = 1'b0;
		pc_advance = 1'b0;
		pc_load = 1'b0;
		pc_target = 8'h00;
		pins_a = 6'(rnd());
		pins_b = rnd();
		pins_c = rnd();
		foreach (mem[i])
			mem[i] = 8'h00;
		mem[3] = 8'h18;
		pc_m = 13'h0000;
		repeat (2) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		rd_all();
		for (int a = 1; a < 32; a++)
			wr(7'(a), a == 3 ? rnd() & 8'h07 : (a == 4 ? rnd() & 8'h1F : rnd()));
		wr(7'h28, 8'hFF);
		rd_all();
		rd(7'h28);
		`CHK(latch_a, mem[5][5:0])
		`CHK(latch_b, mem[6])
		`CHK(latch_c, mem[7])
		wr(7'h04, 8'h0A);
		wr(7'h00, 8'h3C);
		rd(7'h0A);
		wr(7'h04, 8'h0B);
		wr(7'h00, 8'hA5);
		rd(7'h0B);
		rd(7'h00);
		wr(7'h0A, 8'hF5);
		@(posedge i_ref_clk);
		pc_target <= rnd();
		pc_load <= 1'b1;
		@(posedge i_ref_clk);
		pc_load <= 1'b0;
		pc_advance <= 1'b1;
		#1;
		`CHK(pc, {5'h15, pc_target})
		@(posedge i_ref_clk);
		pc_advance <= 1'b0;
		#1;
		pc_m = {5'h15, pc_target} + 13'h0001;
		`CHK(pc, pc_m)
		wr(7'h02, 8'h77);
		`CHK(pc, 13'h1577)
		rd(7'h02);
		wr(7'h03, 8'h20);
		wr(7'h0A, 8'h0C);
		wr(7'h0C, 8'h99);
		for (int a = 0; a < 16; a++)
			rd(7'(a));
		wr(7'h03, 8'h00);
		rd(7'h0A);
		@(posedge i_ref_clk);
		sleeping <= 1'b1;
		wdt_timeout <= 1'b1;
		@(posedge i_ref_clk);
		wdt_timeout <= 1'b0;
		other_reset(1'b1);
		rd_all();
		wr(7'h03, 8'h07);
		@(posedge i_ref_clk);
		master_clear_n <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		master_clear_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		other_reset(1'b0);
		rd_all();
		`CHK(latch_b, mem[6])
		@(posedge i_ref_clk);
		sleeping <= 1'b0;
		master_clear_n <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		master_clear_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		other_reset(1'b0);
		rd(7'h03);
		@(posedge i_ref_clk);
		wdt_timeout <= 1'b1;
		@(posedge i_ref_clk);
		wdt_timeout <= 1'b0;
		other_reset(1'b1);
		rd(7'h03);
		`CHK(pc, pc_m)
		results();
	end
endmodule : bank0_special_register_map_tb
